/* pif_bank.sv */
// peripheral interrupt flag registers 3-6 and enable registers 1-6
//
// Contract
// - no forwarding without peripheral gate, priority off
// - six enable registers mirroring flag positions
// - serial2 receive flag follows buffer full
// - serial2 transmit flag follows buffer empty
// - charge-time flag set by unit, software clears
// - display flag valid only type-B non-static
// - nonvolatile write-done flag bit 4, software clears; also cleared when a write starts, unless a done pulse comes in the same cycle
// - comparator flags bits 2..0, software clears
// - unimplemented bits ignore writes, read zero
// - small memory variant drops listed bits
// - flag group 5 timer flags, software cleared
// - flag group 4 capture/compare 10..3
// - flag group 3 layout, reset zero
// - enable group 1 bits 6..0, bit 7 zero
// - enable group 2 layout, bit 6 zero
// - enable group 3 mirrors flag group 3
// - flags set regardless of any enable
// - priority on: gate blocks low-priority requests
// - software clears flag before enabling, after service
`timescale 1ns/1ns
module pif_bank
  import pif_pkg::*;
#(
  parameter bit SMALL_PROGRAM_MEM = 1'b0
)
(
  input wire logic mclk_in,                      // system clock
  input wire logic rst_n_in,                     // async reset, active low
  pif_link_if.bank link,                         // access port toward the core
  input wire logic timer5_gate_ev_in,            // timer 5 gate event pulse
  input wire logic display_ev_in,                // display frame event pulse
  input wire logic display_typeb_nonstatic_in,   // display in type-B non-static mode
  input wire logic serial2_rx_full_in,           // serial 2 receive buffer full
  input wire logic serial2_tx_empty_in,          // serial 2 transmit buffer empty
  input wire logic charge_time_ev_in,            // charge-time unit event pulse
  input wire logic calendar_ev_in,               // calendar clock event pulse
  input wire logic [9:0] capcomp_ev_in,          // capture/compare 10..1 events
  input wire logic [9:0] capcomp_pwm_in,         // capture/compare 10..1 in PWM mode
  input wire logic [7:0] timer_ev_in,            // group 5 timer events, flag order
  input wire logic nv_write_start_in,            // nonvolatile write started pulse
  input wire logic nv_write_done_in,             // nonvolatile write done pulse
  input wire logic [2:0] comparator_ev_in,       // comparator 3..1 events
  input wire logic [7:0] ext_flags1_in,          // flag group 1 from outside
  input wire logic [7:0] ext_flags2_in           // flag group 2 from outside
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] flag_q [NUM_FLAG_REGS];
  logic [7:0] flag_d [NUM_FLAG_REGS];
  logic [7:0] en_q [NUM_EN_REGS];
  logic [7:0] set_ev [NUM_FLAG_REGS];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic irq_q;
  logic irq_d;
  logic [7:0] rd_word;
  logic [7:0] group3_live;
  logic [9:0] capcomp_set;

  // next value of a software-writable bit set; set wins over clear
  function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic [7:0] set,
                                             input logic hit, input logic [7:0] wdata,
                                             input logic [7:0] wmask);
    logic [7:0] v;
    v = hit ? ((cur & ~wmask) | (wdata & wmask)) : cur;
    return v | set;
  endfunction

  // ------------------------------------------------------------
  // hardware set events
  // ------------------------------------------------------------
  always_comb
  begin
    capcomp_set = capcomp_ev_in & ~capcomp_pwm_in;
    set_ev[0] = RESET_VALUE;
    set_ev[0][BIT_TIMER5_GATE] = timer5_gate_ev_in;
    set_ev[0][BIT_DISPLAY] = display_ev_in & display_typeb_nonstatic_in;
    set_ev[0][BIT_CHARGE_TIME] = charge_time_ev_in;
    set_ev[0][BIT_CAPCOMP2] = capcomp_set[1];
    set_ev[0][BIT_CAPCOMP1] = capcomp_set[0];
    set_ev[0][BIT_CALENDAR] = calendar_ev_in;
    set_ev[1] = capcomp_set[9:2];
    set_ev[2] = timer_ev_in;
    set_ev[3] = RESET_VALUE;
    set_ev[3][BIT_NV_WRITE] = nv_write_done_in;
    set_ev[3][2:0] = comparator_ev_in;
  end

  // ------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_FLAG_REGS; i++)
    begin
      flag_d[i] = merge_write(flag_q[i], set_ev[i], link.reg_wr && (link.reg_sel == 4'(i)),
                              link.reg_wdata,
                              pif_impl_mask(4'(i), SMALL_PROGRAM_MEM) & ~(i == 0 ? HW_ONLY_FLAGS3 : RESET_VALUE));
      flag_d[i] = flag_d[i] & pif_impl_mask(4'(i), SMALL_PROGRAM_MEM);
    end
    flag_d[0][BIT_SERIAL2_RX] = serial2_rx_full_in;
    flag_d[0][BIT_SERIAL2_TX] = serial2_tx_empty_in;
    if (nv_write_start_in && !nv_write_done_in)
    begin
      flag_d[3][BIT_NV_WRITE] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_FLAG_REGS; i++)
      begin
        flag_q[i] <= RESET_VALUE;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_FLAG_REGS; i++)
      begin
        flag_q[i] <= flag_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // enable registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_EN_REGS; i++)
      begin
        en_q[i] <= RESET_VALUE;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_EN_REGS; i++)
      begin
        en_q[i] <= merge_write(en_q[i], RESET_VALUE,
                               link.reg_wr && (link.reg_sel == IDX_EN1 + 4'(i)),
                               link.reg_wdata, pif_impl_mask(IDX_EN1 + 4'(i), SMALL_PROGRAM_MEM));
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb
  begin
    rd_word = RESET_VALUE;
    if (link.reg_sel < IDX_EN1)
    begin
      rd_word = flag_q[link.reg_sel[1:0]];
    end
    else if (link.reg_sel <= IDX_EN6)
    begin
      rd_word = en_q[3'(link.reg_sel - IDX_EN1)];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= RESET_VALUE;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= link.reg_rd;
      if (link.reg_rd)
      begin
        rdata_q <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------
  // request toward the core
  // ------------------------------------------------------------
  always_comb
  begin
    group3_live = flag_q[0] & en_q[2];
    group3_live[BIT_DISPLAY] = group3_live[BIT_DISPLAY] & display_typeb_nonstatic_in;
    irq_d = |(ext_flags1_in & en_q[0]) | |(ext_flags2_in & en_q[1]) | |group3_live
            | |(flag_q[1] & en_q[3]) | |(flag_q[2] & en_q[4]) | |(flag_q[3] & en_q[5]);
  end

  // all bank sources count as low priority, so one gate serves both schemes
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d & link.peripheral_irq_gate;
    end
  end

  assign link.reg_rdata = rdata_q;
  assign link.reg_rvalid = rvalid_q;
  assign link.periph_irq_req = irq_q;

endmodule

/* pif_core.sv */
// core end: register access master and global interrupt gating
`timescale 1ns/1ns
module pif_core
  import pif_pkg::*;
(
  input wire logic mclk_in,                // system clock
  input wire logic rst_n_in,               // async reset, active low
  pif_link_if.core link,                   // link toward the bank
  input wire logic cmd_valid_in,           // access request
  input wire logic cmd_write_in,           // 1 write, 0 read
  input wire logic [3:0] cmd_sel_in,       // register index
  input wire logic [7:0] cmd_wdata_in,     // write data
  input wire logic global_irq_gate_in,     // global interrupt gate
  input wire logic peripheral_irq_gate_in, // peripheral interrupt gate
  input wire logic priority_scheme_on_in,  // priority scheme enabled
  output logic resp_valid_out,             // read data valid pulse
  output logic [7:0] resp_data_out,        // read data
  output logic core_irq_out                // interrupt taken by the core
);

  // ------------------------------------------------------------
  // access issue
  // ------------------------------------------------------------
  logic [3:0] sel_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] wdata_q;
  logic pgate_q;
  logic prio_q;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_q <= IDX_FLAGS3;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      wdata_q <= RESET_VALUE;
    end
    else
    begin
      wr_q <= cmd_valid_in & cmd_write_in;
      rd_q <= cmd_valid_in & ~cmd_write_in;
      if (cmd_valid_in)
      begin
        sel_q <= cmd_sel_in;
        wdata_q <= cmd_wdata_in;
      end
    end
  end

  // ------------------------------------------------------------
  // gate bits and answers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pgate_q <= 1'b0;
      prio_q <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= RESET_VALUE;
      core_irq_out <= 1'b0;
    end
    else
    begin
      pgate_q <= peripheral_irq_gate_in;
      prio_q <= priority_scheme_on_in;
      resp_valid_out <= link.reg_rvalid;
      if (link.reg_rvalid)
      begin
        resp_data_out <= link.reg_rdata;
      end
      core_irq_out <= link.periph_irq_req & global_irq_gate_in;
    end
  end

  assign link.reg_sel = sel_q;
  assign link.reg_wr = wr_q;
  assign link.reg_rd = rd_q;
  assign link.reg_wdata = wdata_q;
  assign link.peripheral_irq_gate = pgate_q;
  assign link.priority_scheme_on = prio_q;

endmodule

/* pif_link_asserts.sv */
// link checker for the peripheral flag and enable bank
`timescale 1ns/1ns
module pif_link_asserts
  import pif_pkg::*;
(
  input wire logic mclk_in,             // system clock
  input wire logic rst_n_in,            // async reset, active low
  input wire logic [3:0] reg_sel,       // register index
  input wire logic reg_wr,              // write pulse
  input wire logic reg_rd,              // read pulse
  input wire logic [7:0] reg_wdata,     // write data
  input wire logic [7:0] reg_rdata,     // read data
  input wire logic reg_rvalid,          // read data valid
  input wire logic peripheral_irq_gate, // peripheral gate
  input wire logic priority_scheme_on,  // priority scheme on
  input wire logic periph_irq_req       // request toward core
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_en3_wr;
    reg_wr && reg_sel == IDX_EN3;
  endsequence
  sequence s_en3_rd;
    !reg_wr ##1 reg_rd && reg_sel == IDX_EN3;
  endsequence

  AST_RVALID_AFTER_RD: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no valid");
  AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid without read");
  AST_RDATA_HOLDS: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  AST_EN3_WRITE_READ: assert property (s_en3_wr ##1 s_en3_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("enable 3 lost write");
  AST_UNMAPPED_ZERO: assert property (reg_rd && reg_sel > IDX_EN6 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAGS6_GAPS: assert property (reg_rd && reg_sel == IDX_FLAGS6 |=> (reg_rdata & ~MASK_GROUP6) == 8'h00)
    else $error("flag 6 gap bits set");
  AST_EN1_TOP: assert property (reg_rd && reg_sel == IDX_EN1 |=> !reg_rdata[7])
    else $error("enable 1 bit 7 set");
  AST_EN2_GAP: assert property (reg_rd && reg_sel == IDX_EN2 |=> !reg_rdata[6])
    else $error("enable 2 bit 6 set");
  AST_REQ_NEEDS_GATE: assert property (periph_irq_req |-> $past(peripheral_irq_gate))
    else $error("request without gate");
  AST_PRIO_GATE_BLOCKS: assert property (priority_scheme_on && !peripheral_irq_gate |=> !periph_irq_req)
    else $error("low priority request passed closed gate");
endmodule

/* pif_link_if.sv */
// register access and request link between the core end and the bank end
`timescale 1ns/1ns
interface pif_link_if;
  logic [3:0] reg_sel;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic peripheral_irq_gate;
  logic priority_scheme_on;
  logic periph_irq_req;

  modport bank
  (
    input reg_sel, reg_wr, reg_rd, reg_wdata, peripheral_irq_gate, priority_scheme_on,
    output reg_rdata, reg_rvalid, periph_irq_req
  );

  modport core
  (
    output reg_sel, reg_wr, reg_rd, reg_wdata, peripheral_irq_gate, priority_scheme_on,
    input reg_rdata, reg_rvalid, periph_irq_req
  );
endinterface

/* pif_pkg.sv */
// shared constants for the peripheral interrupt flag and enable bank
package pif_pkg;

  // ------------------------------------------------------------
  // register indices on the access port
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_FLAGS3 = 4'h0;
  localparam logic [3:0] IDX_FLAGS4 = 4'h1;
  localparam logic [3:0] IDX_FLAGS5 = 4'h2;
  localparam logic [3:0] IDX_FLAGS6 = 4'h3;
  localparam logic [3:0] IDX_EN1 = 4'h4;
  localparam logic [3:0] IDX_EN2 = 4'h5;
  localparam logic [3:0] IDX_EN3 = 4'h6;
  localparam logic [3:0] IDX_EN4 = 4'h7;
  localparam logic [3:0] IDX_EN5 = 4'h8;
  localparam logic [3:0] IDX_EN6 = 4'h9;
  localparam int NUM_FLAG_REGS = 4;
  localparam int NUM_EN_REGS = 6;

  // ------------------------------------------------------------
  // implemented bits and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_GROUP4_SMALL = 8'h3F;
  localparam logic [7:0] MASK_GROUP5_SMALL = 8'h17;
  localparam logic [7:0] MASK_GROUP6 = 8'h17;
  localparam logic [7:0] MASK_EN1 = 8'h7F;
  localparam logic [7:0] MASK_EN2 = 8'hBF;
  localparam logic [7:0] HW_ONLY_FLAGS3 = 8'h30;

  // ------------------------------------------------------------
  // field positions of flag and enable group 3 and group 6
  // ------------------------------------------------------------
  localparam int BIT_TIMER5_GATE = 7;
  localparam int BIT_DISPLAY = 6;
  localparam int BIT_SERIAL2_RX = 5;
  localparam int BIT_SERIAL2_TX = 4;
  localparam int BIT_CHARGE_TIME = 3;
  localparam int BIT_CAPCOMP2 = 2;
  localparam int BIT_CAPCOMP1 = 1;
  localparam int BIT_CALENDAR = 0;
  localparam int BIT_NV_WRITE = 4;

  // implemented bits of a register, by index and memory variant
  function automatic logic [7:0] pif_impl_mask(input logic [3:0] idx, input logic small_mem);
    logic [7:0] m;
    m = RESET_VALUE;
    unique case (idx)
      IDX_FLAGS3, IDX_EN3: m = MASK_FULL;
      IDX_FLAGS4, IDX_EN4: m = small_mem ? MASK_GROUP4_SMALL : MASK_FULL;
      IDX_FLAGS5, IDX_EN5: m = small_mem ? MASK_GROUP5_SMALL : MASK_FULL;
      IDX_FLAGS6, IDX_EN6: m = MASK_GROUP6;
      IDX_EN1: m = MASK_EN1;
      IDX_EN2: m = MASK_EN2;
      default: m = RESET_VALUE;
    endcase
    return m;
  endfunction

endpackage

/* tb_top.sv */
// self-checking bench joining the core end and the bank end
`timescale 1ns/1ns
module tb_top
  import pif_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cv, cw, gg, pg, po, rv, irq, t5g, dsp, typeb, rxf, txe, ctu, cal, nvs, nvd;
  logic [3:0] cs;
  logic [7:0] cd, rdat, tmr, ef1, ef2;
  logic [9:0] ccp, pwm;
  logic [2:0] cmp;
  int err_count = 0;
  int compares = 0;

  always #5 mclk_in = ~mclk_in;

  pif_link_if pif_link_if_inst ();
  pif_core pif_core_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(pif_link_if_inst.core),
    .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_sel_in(cs), .cmd_wdata_in(cd),
    .global_irq_gate_in(gg), .peripheral_irq_gate_in(pg), .priority_scheme_on_in(po),
    .resp_valid_out(rv), .resp_data_out(rdat), .core_irq_out(irq)
  );
  pif_bank pif_bank_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(pif_link_if_inst.bank),
    .timer5_gate_ev_in(t5g), .display_ev_in(dsp), .display_typeb_nonstatic_in(typeb),
    .serial2_rx_full_in(rxf), .serial2_tx_empty_in(txe), .charge_time_ev_in(ctu),
    .calendar_ev_in(cal), .capcomp_ev_in(ccp), .capcomp_pwm_in(pwm), .timer_ev_in(tmr),
    .nv_write_start_in(nvs), .nv_write_done_in(nvd), .comparator_ev_in(cmp),
    .ext_flags1_in(ef1), .ext_flags2_in(ef2)
  );
  pif_link_asserts pif_link_asserts_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_sel(pif_link_if_inst.reg_sel),
    .reg_wr(pif_link_if_inst.reg_wr), .reg_rd(pif_link_if_inst.reg_rd),
    .reg_wdata(pif_link_if_inst.reg_wdata), .reg_rdata(pif_link_if_inst.reg_rdata),
    .reg_rvalid(pif_link_if_inst.reg_rvalid), .peripheral_irq_gate(pif_link_if_inst.peripheral_irq_gate),
    .priority_scheme_on(pif_link_if_inst.priority_scheme_on), .periph_irq_req(pif_link_if_inst.periph_irq_req)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask

  task automatic issue(input logic w, input logic [3:0] sel, input logic [7:0] d);
    tick();
    {cv, cw, cs, cd} = {1'b1, w, sel, d};
    tick();
    cv = 1'b0;
  endtask

  task automatic rd(input logic [3:0] sel, input logic [7:0] exp);
    int n;
    issue(1'b0, sel, 8'h00);
    n = 1;
    while (rv !== 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    if (rv !== 1'b1)
    begin
      err_count++;
      $display("Error at %0t: read answer timed out", $time);
      finish_test();
    end
    else
    begin
      chk(n[7:0], 8'h03);
      chk(rdat, exp);
    end
  endtask

  task automatic irq_is(input logic e);
    chk({7'h00, irq}, {7'h00, e});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_access();
    logic [7:0] m [16];
    m = '{8'hCF, 8'hFF, 8'hFF, 8'h17, 8'h7F, 8'hBF, 8'hFF, 8'hFF,
          8'hFF, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++)
    begin
      rd(i[3:0], 8'h00);
      issue(1'b1, i[3:0], 8'hFF);
      rd(i[3:0], m[i]);
      issue(1'b1, i[3:0], 8'h00);
      rd(i[3:0], 8'h00);
    end
    $display("test_access done");
  endtask

  task automatic test_events();
    rxf = 1'b1;
    tick();
    rd(IDX_FLAGS3, 8'h20);
    {rxf, txe} = 2'b01;
    issue(1'b1, IDX_FLAGS3, 8'h00);
    rd(IDX_FLAGS3, 8'h10);
    {txe, typeb, t5g, dsp, ctu, cal, nvd} = 7'h3F;
    {ccp, tmr, cmp} = '1;
    tick();
    {t5g, dsp, ctu, cal, nvd, ccp, tmr, cmp} = '0;
    rd(IDX_FLAGS3, 8'hCF);
    rd(IDX_FLAGS4, 8'hFF);
    rd(IDX_FLAGS5, 8'hFF);
    rd(IDX_FLAGS6, 8'h17);
    nvs = 1'b1;
    tick();
    nvs = 1'b0;
    rd(IDX_FLAGS6, 8'h07);
    for (int i = 0; i < 4; i++)
      issue(1'b1, i[3:0], 8'h00);
    {typeb, dsp, pwm, ccp} = {2'b01, 10'h3FF, 10'h3FF};
    tick();
    {dsp, pwm, ccp} = '0;
    rd(IDX_FLAGS3, 8'h00);
    rd(IDX_FLAGS4, 8'h00);
    issue(1'b1, IDX_FLAGS6, 8'h00);
    cmp = 3'h1;
    tick();
    cmp = 3'h0;
    rd(IDX_FLAGS6, 8'h01);
    $display("test_events done");
  endtask

  task automatic test_irq();
    gg = 1'b1;
    issue(1'b1, IDX_EN6, 8'h01);
    repeat (3) tick();
    irq_is(1'b0);
    pg = 1'b1;
    repeat (3) tick();
    irq_is(1'b1);
    {po, pg} = 2'b10;
    repeat (3) tick();
    irq_is(1'b0);
    {po, pg, gg} = 3'b010;
    repeat (3) tick();
    irq_is(1'b0);
    gg = 1'b1;
    issue(1'b1, IDX_FLAGS6, 8'h00);
    repeat (3) tick();
    irq_is(1'b0);
    issue(1'b1, IDX_EN3, 8'h01);
    cal = 1'b1;
    tick();
    cal = 1'b0;
    tick();
    irq_is(1'b0);
    tick();
    irq_is(1'b1);
    issue(1'b1, IDX_FLAGS3, 8'h00);
    repeat (3) tick();
    irq_is(1'b0);
    ef1 = 8'h40;
    issue(1'b1, IDX_EN1, 8'h40);
    repeat (3) tick();
    irq_is(1'b1);
    {ef1, ef2} = {8'h00, 8'hC0};
    repeat (3) tick();
    irq_is(1'b0);
    issue(1'b1, IDX_EN2, 8'hC0);
    repeat (3) tick();
    irq_is(1'b1);
    $display("test_irq done");
  endtask

  initial
  begin
    {cv, cw, gg, pg, po, t5g, dsp, typeb, rxf, txe, ctu, cal, nvs, nvd} = '0;
    {cs, cd, tmr, ccp, pwm, cmp, ef1, ef2} = '0;
    repeat (12) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    test_access();
    test_events();
    test_irq();
    finish_test();
  end
endmodule
